// ### hdl/lfp_params.svh
// Constants for the laser front-panel state controller.
`ifndef LFP_PARAMS_SVH
`define LFP_PARAMS_SVH

`define LFP_CLK_HZ          40000000
`define LFP_WARMUP_S        90
`define LFP_BOOT_S          15
`define LFP_BLINK_HALF_MS   250
`define LFP_BLINK_CYC       ((`LFP_CLK_HZ / 1000) * `LFP_BLINK_HALF_MS)
`define LFP_MENU_ITEMS      4
`define LFP_REP_MIN         8'h14
`define LFP_REP_MAX         8'hff
`define LFP_REP_RST         8'h64
`define LFP_CUR_MAX         8'hff
`define LFP_CUR_RST         8'h80
`define LFP_ADDR_CTRL       12'h000
`define LFP_ADDR_STATUS     12'h004
`define LFP_ADDR_MENU       12'h008
`define LFP_ADDR_PARAM      12'h00c
`define LFP_CTRL_DIODE_ON   0
`define LFP_CTRL_STANDBY    1
`define LFP_CTRL_PULSE      2
`define LFP_CTRL_CONT       3
`define LFP_CTRL_FLT_CLR    4

`endif

// ### hdl/lfp_pkg.sv
// Types shared by the laser front-panel state controller.
package lfp_pkg;
    typedef enum logic [1:0] {
        LFP_STANDBY,
        LFP_CONTINUOUS,
        LFP_PULSED
    } lfp_mode_e;

    typedef enum logic [1:0] {
        LFP_MENU_STATUS,
        LFP_MENU_REPRATE,
        LFP_MENU_CURRENT,
        LFP_MENU_FAULT
    } lfp_menu_e;
endpackage

// ### hdl/lfp_sync.sv
// Two-flop synchroniser with rising-edge pulse for one input pin.
`timescale 1ns/1ps
`default_nettype none
module lfp_sync (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic din,
    output logic      level,
    output logic      rise
);
    logic meta_q;
    logic sync_q;
    logic last_q;
    logic meta_d;
    logic sync_d;
    logic last_d;

    always_comb begin
        meta_d = din;
        sync_d = meta_q;
        last_d = sync_q;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            last_q <= last_d;
        end
    end

    assign level = sync_q;
    assign rise  = sync_q & ~last_q;
endmodule
`default_nettype wire

// ### hdl/lfp_ctrl.sv
// Front-panel state controller of a pulsed laser power supply.
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "lfp_params.svh"
module lfp_ctrl
    import lfp_pkg::*;
#(
    parameter int unsigned SEC_CYC = `LFP_CLK_HZ
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        btn_on,
    input  wire logic        diode_off_button,
    input  wire logic        pulse_toggle_button,
    input  wire logic        btn_menu,
    input  wire logic        btn_up,
    input  wire logic        btn_down,
    input  wire logic        remote_start_n,
    input  wire logic        remote_sel_n,
    input  wire logic        safety_loop_open,
    input  wire logic        fault_persist,
    input  wire logic        fault_transient,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             diode_en,
    output logic             qswitch_en,
    output logic             ready_led,
    output logic             enable_led,
    output logic             emission_led,
    output logic             safety_loop_indicator,
    output logic             fault_led,
    output logic             fault_out,
    output logic [1:0]       menu_sel,
    output logic [7:0]       rep_rate,
    output logic [7:0]       diode_current
);
    localparam int unsigned WARM_CYC = `LFP_WARMUP_S * SEC_CYC;
    localparam int unsigned BOOT_CYC = `LFP_BOOT_S * SEC_CYC;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers; every pin passes two flops first.

    logic [10:0] pin_raw;
    logic [10:0] pin_lvl;
    logic [10:0] pin_rise;

    assign pin_raw = {fault_transient, fault_persist, safety_loop_open,
                      ~remote_sel_n, ~remote_start_n, btn_down, btn_up,
                      btn_menu, pulse_toggle_button, diode_off_button,
                      btn_on};

    genvar gi;
    generate
        for (gi = 0; gi < 11; gi++) begin : g_sync
            lfp_sync u_sync (
                .clk    (clk),
                .resetn (resetn),
                .din    (pin_raw[gi]),
                .level  (pin_lvl[gi]),
                .rise   (pin_rise[gi])
            );
        end
    endgenerate

    logic remote_mode;
    logic panel_ok;
    logic p_on;
    logic p_off;
    logic p_tog;
    logic p_menu;
    logic p_up;
    logic p_down;
    logic r_start;
    logic r_stop;
    logic flt_now;
    lfp_mode_e mode_q, mode_d;

    // Remote select is inverted before its synchroniser so that the
    // cleared flops after reset read as panel mode, its idle level.
    // remote locks panel
    assign remote_mode = pin_lvl[7];
    assign panel_ok    = ~remote_mode;
    assign p_on        = pin_rise[0] & panel_ok;
    assign p_off       = pin_rise[1] & panel_ok;
    assign p_tog       = pin_rise[2] & panel_ok;
    assign p_menu      = pin_rise[3] & panel_ok;
    assign p_up        = pin_rise[4] & panel_ok;
    assign p_down      = pin_rise[5] & panel_ok;
    assign r_start     = pin_rise[6] & remote_mode;
    assign r_stop      = ~pin_lvl[6] & remote_mode & (mode_q != LFP_STANDBY);
    assign flt_now     = pin_lvl[9] | pin_lvl[10];

    ////////////////////////////////////////////////////////////////////////
    // APB register access; zero wait states.

    logic       wr_acc;
    logic [4:0] ctrl_wr;

    assign wr_acc  = psel & penable & pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    always_comb begin
        ctrl_wr = 5'h00;
        if (wr_acc && paddr == `LFP_ADDR_CTRL) begin
            ctrl_wr = pwdata[4:0];
        end
    end

    logic any_btn;
    logic s_on;
    logic s_off;
    logic s_pul;
    logic s_cont;
    logic s_clr;

    assign any_btn = |pin_rise[5:0] | remote_mode;
    assign s_on    = ctrl_wr[`LFP_CTRL_DIODE_ON] & ~any_btn;
    assign s_off   = ctrl_wr[`LFP_CTRL_STANDBY] & ~any_btn;
    assign s_pul   = ctrl_wr[`LFP_CTRL_PULSE] & ~any_btn;
    assign s_cont  = ctrl_wr[`LFP_CTRL_CONT] & ~any_btn;
    assign s_clr   = ctrl_wr[`LFP_CTRL_FLT_CLR] & ~any_btn;

    ////////////////////////////////////////////////////////////////////////
    // Laser mode, fault latch and timers.

    logic        fault_q, fault_d;
    logic [31:0] warm_q, warm_d;
    logic [31:0] boot_q, boot_d;
    logic [31:0] blink_q, blink_d;
    logic        blink_ph_q, blink_ph_d;
    logic        go_on;
    logic        go_off;
    logic        clr_flt;

    assign go_on   = p_on | r_start | s_on;
    assign go_off  = p_off | r_stop | s_off;
    assign clr_flt = p_off | r_start | s_clr | s_off;

    always_comb begin
        mode_d     = mode_q;
        fault_d    = fault_q;
        warm_d     = warm_q;
        boot_d     = boot_q;
        blink_d    = blink_q;
        blink_ph_d = blink_ph_q;
        if (blink_q == `LFP_BLINK_CYC - 1) begin
            blink_d    = 32'h0;
            blink_ph_d = ~blink_ph_q;
        end else begin
            blink_d = blink_q + 32'h1;
        end
        if (boot_q != 32'h0) begin
            boot_d = boot_q - 32'h1;
        end
        if (warm_q != 32'h0) begin
            warm_d = warm_q - 32'h1;
        end
        if (clr_flt && !pin_lvl[9]) begin
            fault_d = 1'b0;
        end
        if (flt_now) begin
            fault_d = 1'b1;
        end
        case (mode_q)
            LFP_STANDBY: begin
                if (go_on && !fault_d) begin
                    mode_d = LFP_CONTINUOUS;
                    warm_d = WARM_CYC;
                end
            end
            LFP_CONTINUOUS: begin
                if (p_tog || s_pul) begin
                    mode_d = LFP_PULSED;
                end
            end
            LFP_PULSED: begin
                if (p_tog || s_cont) begin
                    mode_d = LFP_CONTINUOUS;
                end
            end
            default: mode_d = LFP_STANDBY;
        endcase
        if (go_off) begin
            mode_d = LFP_STANDBY;
        end
        if (fault_d) begin
            mode_d = LFP_STANDBY;
        end
        if (mode_d == LFP_STANDBY) begin
            warm_d = 32'h0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_q     <= LFP_STANDBY;
            fault_q    <= 1'b0;
            warm_q     <= 32'h0;
            boot_q     <= BOOT_CYC;
            blink_q    <= 32'h0;
            blink_ph_q <= 1'b0;
        end else begin
            mode_q     <= mode_d;
            fault_q    <= fault_d;
            warm_q     <= warm_d;
            boot_q     <= boot_d;
            blink_q    <= blink_d;
            blink_ph_q <= blink_ph_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Menu selection and parameters.

    function automatic logic [7:0] step(input logic [7:0] v,
                                        input logic       up,
                                        input logic       dn,
                                        input logic [7:0] lo,
                                        input logic [7:0] hi);
        logic [7:0] r;
        r = v;
        if (up && v < hi) begin
            r = v + 8'h01;
        end else if (dn && v > lo) begin
            r = v - 8'h01;
        end
        return r;
    endfunction

    lfp_menu_e  menu_q, menu_d;
    logic [7:0] rep_q, rep_d;
    logic [7:0] cur_q, cur_d;

    always_comb begin
        menu_d = menu_q;
        rep_d  = rep_q;
        cur_d  = cur_q;
        if (p_menu) begin
            menu_d = lfp_menu_e'(2'(menu_q + 2'h1));
        end
        if (go_on || go_off || s_cont) begin
            menu_d = LFP_MENU_STATUS;
        end
        if (mode_d == LFP_PULSED && mode_q != LFP_PULSED) begin
            menu_d = LFP_MENU_REPRATE;
        end
        if (fault_d && !fault_q) begin
            menu_d = LFP_MENU_FAULT;
        end
        case (menu_q)
            LFP_MENU_REPRATE: rep_d = step(rep_q, p_up, p_down,
                                           `LFP_REP_MIN, `LFP_REP_MAX);
            LFP_MENU_CURRENT: cur_d = step(cur_q, p_up, p_down,
                                           8'h00, `LFP_CUR_MAX);
            default: ;
        endcase
        if (wr_acc && paddr == `LFP_ADDR_MENU) begin
            menu_d = lfp_menu_e'(pwdata[1:0]);
        end
        if (wr_acc && paddr == `LFP_ADDR_PARAM && !any_btn) begin
            if (pwdata[7:0] >= `LFP_REP_MIN) begin
                rep_d = pwdata[7:0];
            end
            cur_d = pwdata[15:8];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            menu_q <= LFP_MENU_STATUS;
            rep_q  <= `LFP_REP_RST;
            cur_q  <= `LFP_CUR_RST;
        end else begin
            menu_q <= menu_d;
            rep_q  <= rep_d;
            cur_q  <= cur_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Indicators and read data.

    logic diode_on;
    logic booting;

    assign diode_on = mode_q != LFP_STANDBY;
    assign booting  = boot_q != 32'h0;

    logic [31:0] rd_d, rd_q;

    always_comb begin
        case (paddr)
            `LFP_ADDR_CTRL:   rd_d = 32'h0;
            `LFP_ADDR_STATUS: rd_d = {24'h0, 2'h0, booting, warm_q != 32'h0,
                                      fault_q, pin_lvl[8], mode_q};
            `LFP_ADDR_MENU:   rd_d = {30'h0, menu_q};
            `LFP_ADDR_PARAM:  rd_d = {16'h0, cur_q, rep_q};
            default:          rd_d = 32'h0;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_q <= 32'h0;
        end else begin
            rd_q <= rd_d;
        end
    end

    assign prdata = rd_q;

    assign diode_en     = diode_on;
    assign emission_led = diode_on;
    assign qswitch_en   = mode_q == LFP_PULSED;
    assign enable_led   = mode_q == LFP_PULSED;
    assign ready_led    = diode_on & ((warm_q == 32'h0) | blink_ph_q);
    assign safety_loop_indicator = booting ? blink_ph_q : pin_lvl[8];
    assign fault_led    = fault_q;
    assign fault_out    = fault_q;
    assign menu_sel     = menu_q;
    assign rep_rate     = rep_q;
    assign diode_current = cur_q;
endmodule
`default_nettype wire

// ### test/lfp_ctrl_checker.sv
// Concurrent checks on the laser front-panel controller ports.
`timescale 1ns/1ps
`default_nettype none
module lfp_ctrl_checker (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       fault_persist,
    input wire logic       diode_en,
    input wire logic       qswitch_en,
    input wire logic       ready_led,
    input wire logic       enable_led,
    input wire logic       emission_led,
    input wire logic       fault_led,
    input wire logic       fault_out,
    input wire logic [1:0] menu_sel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    AST_DIODE_EMIS: assert property (emission_led == diode_en)
        else $error("emission led differs from diode drive");
    AST_ENABLE_PULSE: assert property (enable_led == qswitch_en)
        else $error("enable led differs from pulsed mode");
    AST_QSW_DIODE: assert property (qswitch_en |-> diode_en)
        else $error("pulsing without diode drive");
    AST_FAULT_LED: assert property (fault_led == fault_out)
        else $error("fault led differs from fault latch");
    AST_FAULT_STOP: assert property ($rose(fault_out) |->
        ##[0:1] (!diode_en && !qswitch_en))
        else $error("emission kept after fault");
    AST_STANDBY_DARK: assert property ($fell(diode_en) |->
        (!ready_led && !emission_led))
        else $error("indicators lit in standby");
    AST_PULSE_MENU: assert property ($rose(qswitch_en) |->
        ##[0:1] (menu_sel == 2'h1))
        else $error("rate item not shown on pulsing");
    AST_FAULT_MENU: assert property ($rose(fault_out) |->
        ##[0:1] (menu_sel == 2'h3))
        else $error("fault item not shown on fault");
    AST_FAULT_HOLD: assert property (fault_out && fault_persist |=>
        fault_out)
        else $error("fault latch dropped while fault present");

    cover property ($rose(qswitch_en));
    cover property ($rose(fault_out));
    cover property ($rose(ready_led));
endmodule

bind lfp_ctrl lfp_ctrl_checker u_chk (
    .clk(clk), .resetn(resetn), .fault_persist(fault_persist),
    .diode_en(diode_en), .qswitch_en(qswitch_en), .ready_led(ready_led),
    .enable_led(enable_led), .emission_led(emission_led),
    .fault_led(fault_led), .fault_out(fault_out), .menu_sel(menu_sel)
);
`default_nettype wire

// ### test/lfp_panel_model.sv
// Operator model: holds one pressed button for a few cycles.
`timescale 1ns/1ps
`default_nettype none
module lfp_panel_model (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [5:0] press,
    output logic      [5:0] btn
);
    logic [5:0] btn_q;
    logic [5:0] btn_d;
    logic [2:0] hold_q;
    logic [2:0] hold_d;

    always_comb begin
        btn_d  = btn_q;
        hold_d = hold_q;
        if (press != 6'h00) begin
            btn_d  = press;
            hold_d = 3'h4;
        end else if (hold_q != 3'h0) begin
            hold_d = hold_q - 3'h1;
            if (hold_q == 3'h1) begin
                btn_d = 6'h00;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            btn_q  <= 6'h00;
            hold_q <= 3'h0;
        end else begin
            btn_q  <= btn_d;
            hold_q <= hold_d;
        end
    end

    assign btn = btn_q;
endmodule
`default_nettype wire

// ### test/testbench.sv
// Self-checking testbench for the laser front-panel controller.
`timescale 1ns/1ps
`default_nettype none
`include "lfp_params.svh"
module testbench;
    import lfp_pkg::*;
    localparam int unsigned SEC = 100;
    logic        clk, resetn, rs_n, rsel_n, loop, fp, ft;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0]  pr, btn;
    logic        diode_en, qswitch_en, ready_led, enable_led, emission_led;
    logic        sli, fault_led, fault_out;
    logic [1:0]  menu_sel;
    logic [7:0]  rep_rate, diode_current;
    int          error_cnt, samples_checked;

    lfp_panel_model u_panel (.clk(clk), .resetn(resetn), .press(pr),
        .btn(btn));
    lfp_ctrl #(.SEC_CYC(SEC)) dut (
        .clk(clk), .resetn(resetn), .btn_on(btn[0]),
        .diode_off_button(btn[1]), .pulse_toggle_button(btn[2]),
        .btn_menu(btn[3]), .btn_up(btn[4]), .btn_down(btn[5]),
        .remote_start_n(rs_n), .remote_sel_n(rsel_n),
        .safety_loop_open(loop), .fault_persist(fp),
        .fault_transient(ft), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .diode_en(diode_en),
        .qswitch_en(qswitch_en), .ready_led(ready_led),
        .enable_led(enable_led), .emission_led(emission_led),
        .safety_loop_indicator(sli), .fault_led(fault_led),
        .fault_out(fault_out), .menu_sel(menu_sel), .rep_rate(rep_rate),
        .diode_current(diode_current));

    always #12.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic wt;
        repeat (10) @(posedge clk);
    endtask

    task automatic press(input int i);
        @(posedge clk);
        pr <= 6'h01 << i;
        @(posedge clk);
        pr <= 6'h00;
        wt;
    endtask

    // Setup cycle, then access held until pready is sampled high.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk(diode_en, 0);
        chk({menu_sel, rep_rate, diode_current}, 18'h06480);
        apb(1'b0, `LFP_ADDR_STATUS, 32'h0);
        chk(rd, 32'h20);
        apb(1'b1, 12'h010, 32'hffff);
        chk(pslverr, 1'b0);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h0);
        $display("reset test done");
    endtask

    task automatic t_boot;
        @(posedge clk) loop <= 1'b1;
        wt;
        chk(sli, 0);
        repeat (15 * SEC) @(posedge clk);
        chk(sli, 1);
        @(posedge clk) loop <= 1'b0;
        wt;
        chk(sli, 0);
        $display("boot test done");
    endtask

    task automatic t_on;
        press(0);
        chk({diode_en, emission_led, ready_led}, 3'b110);
        apb(1'b0, `LFP_ADDR_STATUS, 32'h0);
        chk(rd, 32'h11);
        repeat (90 * SEC) @(posedge clk);
        chk(ready_led, 1);
        $display("on test done");
    endtask

    task automatic t_pulse;
        press(2);
        chk({qswitch_en, enable_led, menu_sel}, 4'b1101);
        press(2);
        chk({diode_en, qswitch_en, enable_led}, 3'b100);
        $display("pulse test done");
    endtask

    task automatic t_menu;
        apb(1'b1, `LFP_ADDR_MENU, 32'h0);
        for (int i = 1; i <= 4; i++) begin
            press(3);
            chk(menu_sel, i % 4);
        end
        $display("menu test done");
    endtask

    task automatic t_param;
        apb(1'b1, `LFP_ADDR_MENU, 32'h1);
        apb(1'b1, `LFP_ADDR_PARAM, 32'h8014);
        press(5);
        chk(rep_rate, 8'h14);
        apb(1'b1, `LFP_ADDR_PARAM, 32'h8013);
        chk(rep_rate, 8'h14);
        press(4);
        chk(rep_rate, 8'h15);
        $display("param test done");
    endtask

    task automatic t_serial;
        apb(1'b1, `LFP_ADDR_CTRL, 32'h1);
        apb(1'b0, `LFP_ADDR_STATUS, 32'h0);
        chk(rd, 32'h11);
        apb(1'b1, `LFP_ADDR_CTRL, 32'h4);
        wt;
        chk({qswitch_en, menu_sel}, 3'b101);
        apb(1'b1, `LFP_ADDR_CTRL, 32'h8);
        wt;
        chk({diode_en, qswitch_en, menu_sel}, 4'b1000);
        apb(1'b1, `LFP_ADDR_CTRL, 32'h2);
        wt;
        chk(diode_en, 1'b0);
        apb(1'b1, `LFP_ADDR_MENU, 32'h2);
        press(4);
        chk(diode_current, 8'h81);
        $display("serial test done");
    endtask

    task automatic t_fault;
        press(2);
        @(posedge clk) ft <= 1'b1;
        wt;
        chk({diode_en, qswitch_en, ready_led}, 3'b000);
        chk({fault_led, fault_out, menu_sel}, 4'hf);
        @(posedge clk) ft <= 1'b0;
        wt;
        chk(fault_out, 1);
        press(1);
        chk(fault_out, 0);
        @(posedge clk) fp <= 1'b1;
        wt;
        press(1);
        chk(fault_out, 1);
        @(posedge clk) fp <= 1'b0;
        wt;
        press(1);
        chk(fault_out, 0);
        $display("fault test done");
    endtask

    task automatic t_remote;
        @(posedge clk) rsel_n <= 1'b0;
        wt;
        press(0);
        chk(diode_en, 0);
        apb(1'b1, `LFP_ADDR_CTRL, 32'h1);
        wt;
        chk(diode_en, 0);
        @(posedge clk) rs_n <= 1'b0;
        wt;
        chk(diode_en, 1);
        @(posedge clk) ft <= 1'b1;
        wt;
        @(posedge clk) ft <= 1'b0;
        @(posedge clk) rs_n <= 1'b1;
        wt;
        chk({diode_en, fault_out}, 2'b01);
        @(posedge clk) rs_n <= 1'b0;
        wt;
        chk({diode_en, fault_out}, 2'b10);
        @(posedge clk) rs_n <= 1'b1;
        wt;
        chk(diode_en, 0);
        $display("remote test done");
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        {rs_n, rsel_n, loop, fp, ft} = 5'b11000;
        {psel, penable, pwrite, paddr, pwdata, pr} = '0;
        error_cnt = 0;
        samples_checked = 0;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_reset;
        t_boot;
        t_on;
        t_pulse;
        t_menu;
        t_param;
        t_fault;
        t_serial;
        t_remote;
        final_report;
    end

    initial begin
        #(25.0 * 2 * (105 * SEC + 1500));
        error_cnt++;
        final_report;
    end
endmodule
`default_nettype wire
